//--- pkg/pin_remap_map.vh
// register map, field layout, reset values and codes of the pin remap matrix
`ifndef PIN_REMAP_MAP_VH
`define PIN_REMAP_MAP_VH

// ----------------------------------------
// register indices on the plain port
// ----------------------------------------
`define IN_MAP_BASE    5'h00
`define IN_MAP_LAST    5'h08
`define OUT_MAP_BASE   5'h09
`define OUT_MAP_LAST   5'h10
`define OSC_CTRL_ADDR  5'h11
`define IRQ_STAT_ADDR  5'h12
`define IRQ_MASK_ADDR  5'h13

// ----------------------------------------
// fields
// ----------------------------------------
`define LOCK_BIT       6
`define FUSE_BIT       5
`define HI_LSB         8
`define LO_LSB         0
`define MASK_HI        16'h1f00
`define MASK_LO        16'h001f
`define MASK_BOTH      16'h1f1f

// ----------------------------------------
// reset values
// ----------------------------------------
`define IN_MAP_RST     16'h1f1f
`define OUT_MAP_RST    16'h0000
`define LOCK_RST       1'h0

// ----------------------------------------
// unlock keys and selector codes
// ----------------------------------------
`define KEY_FIRST      8'h46
`define KEY_SECOND     8'h57
`define SEL_GROUND     5'h1f
`define SEL_LAST_PIN   5'h19
`define OUT_NULL       5'h00
`define OUT_TX         5'h03
`define OUT_RTS        5'h04
`define OUT_SDO        5'h07
`define OUT_SCK        5'h08
`define OUT_SS         5'h09
`define OUT_OC1        5'h12
`define OUT_OC2        5'h13

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define EV_REFUSED     0
`define EV_MISMATCH    1
`define EV_LOCK_CHG    2
`define EV_COUNT       3

`endif

//--- hw/peripheral_pin_remap.v
// remappable peripheral pin-select matrix with write lock and shadow check
//
// Overview of operation
// - each input has a 5-bit selector; 11111 grounds it, 0..25 pick a pin
// - output routing is per pin, one 5-bit field chooses the driving peripheral
// - output code 00000 leaves the pin to its default port control
// - code 00011 routes serial transmit, code 00100 routes request-to-send
// - codes 00111, 01000, 01001 route SPI data, clock, select outputs
// - codes 10010 and 10011 route compare channel 1 and 2
// - locked map writes set the refused status bit and leave contents unchanged
// - lock bit 6 of the oscillator control register gates map writes
// - lock changes only after 0x46 then 0x57 to the low byte, then one write
// - lock bit holds until changed, allowing many updates per unlock
// - shadow copies are compared continuously; a mismatch forces a reset
// - with the one-way fuse active, a once-set lock cannot be cleared
// - unprogrammed fuse reads set (one session); programmed allows unlimited
// - seventeen map registers: nine input, eight output
// - unused map bits cannot be written and read as zero
// - irq1 at 12-8 of reg 0, irq2 at 4-0 of reg 1, timers 3/2 in reg 2
// - captures 1,2,7,8, fault A, serial rx/cts, SPI in signals are remappable
`include "pin_remap_map.vh"
`default_nettype none

module peripheral_pin_remap #(
    parameter NUM_PINS = 26,
    parameter NUM_IN   = 9,
    parameter NUM_OUT  = 8
) (
    input  wire                 clk_i,
    input  wire                 rstn_i,
    input  wire                 ce_i,
    input  wire [4:0]           addr_i,
    input  wire [15:0]          wdata_i,
    input  wire                 wr_i,
    input  wire                 rd_i,
    output wire [15:0]          rdata_o,
    input  wire [7:0]           osc_config_word_i,
    input  wire [NUM_PINS-1:0]  pin_in_i,
    input  wire [2*NUM_OUT-1:0] port_data_i,
    input  wire [2*NUM_OUT-1:0] port_drive_i,
    output wire [2*NUM_OUT-1:0] pin_out_o,
    output wire [2*NUM_OUT-1:0] pin_oe_o,
    input  wire                 serial_tx_out_i,
    input  wire                 serial_rts_out_i,
    input  wire                 spi_data_out_i,
    input  wire                 spi_clock_out_i,
    input  wire                 spi_select_out_i,
    input  wire                 compare1_out_i,
    input  wire                 compare2_out_i,
    output wire                 ext_irq1_o,
    output wire                 ext_irq2_o,
    output wire                 timer2_clk_o,
    output wire                 timer3_clk_o,
    output wire                 capture1_o,
    output wire                 capture2_o,
    output wire                 capture7_o,
    output wire                 capture8_o,
    output wire                 compare_fault_a_in_o,
    output wire                 serial_rx_o,
    output wire                 serial_cts_o,
    output wire                 spi_data_in_o,
    output wire                 spi_clock_in_o,
    output wire                 spi_select_in_o,
    output wire                 pin_map_lock_o,
    output wire                 config_reset_o,
    output wire                 irq_o
);

    // ----------------------------------------
    // key sequence states
    // ----------------------------------------
    localparam [1:0] KEY_IDLE = 2'b00;
    localparam [1:0] KEY_HALF = 2'b01;
    localparam [1:0] KEY_OPEN = 2'b10;
    localparam       NOPIN    = 2 * NUM_OUT;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // writable bits of each input map register
    function [15:0] in_mask;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    in_mask = `MASK_HI;
                4'h1:    in_mask = `MASK_LO;
                4'h5:    in_mask = `MASK_LO;
                4'h8:    in_mask = `MASK_LO;
                default: in_mask = `MASK_BOTH;
            endcase
        end
    endfunction

    // input selector to pin level; ground and unused codes give zero
    function route_in;
        input [4:0]          sel;
        input [NUM_PINS-1:0] pins;
        begin
            if (sel <= `SEL_LAST_PIN)
                route_in = pins[sel];
            else
                route_in = 1'b0;
        end
    endfunction

    // output code to {drive, level}
    function [1:0] route_out;
        input [4:0] code;
        input [6:0] per;
        begin
            case (code)
                `OUT_TX:  route_out = {1'b1, per[0]};
                `OUT_RTS: route_out = {1'b1, per[1]};
                `OUT_SDO: route_out = {1'b1, per[2]};
                `OUT_SCK: route_out = {1'b1, per[3]};
                `OUT_SS:  route_out = {1'b1, per[4]};
                `OUT_OC1: route_out = {1'b1, per[5]};
                `OUT_OC2: route_out = {1'b1, per[6]};
                default:  route_out = 2'b00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [15:0]          in_map_ff   [0:NUM_IN-1];
    reg [15:0]          out_map_ff  [0:NUM_OUT-1];
    reg [15:0]          in_shad_ff  [0:NUM_IN-1];
    reg [15:0]          out_shad_ff [0:NUM_OUT-1];
    reg [NUM_PINS-1:0]  sync1_ff;
    reg [NUM_PINS-1:0]  sync2_ff;
    reg [1:0]           key_ff;
    reg                 lock_ff;
    reg                 set_once_ff;
    reg                 fuse_ff;
    reg [`EV_COUNT-1:0] stat_ff;
    reg [`EV_COUNT-1:0] mask_ff;
    reg                 irq_ff;
    reg                 cfg_rst_ff;
    reg [15:0]          rdata_ff;
    reg [NOPIN-1:0]     pin_out_ff;
    reg [NOPIN-1:0]     pin_oe_ff;
    reg [13:0]          pin_sel_ff;

    reg [15:0]          nxt_rdata;
    reg [NOPIN-1:0]     nxt_pin_out;
    reg [NOPIN-1:0]     nxt_pin_oe;
    reg [13:0]          nxt_pin_sel;
    reg [`EV_COUNT-1:0] events;
    reg                 mismatch;
    reg [1:0]           drv;
    reg [4:0]           code;
    integer             i;
    integer             j;

    wire       in_hit  = (addr_i <= `IN_MAP_LAST);
    wire       out_hit = (addr_i >= `OUT_MAP_BASE) && (addr_i <= `OUT_MAP_LAST);
    wire [3:0] in_idx  = addr_i[3:0];
    wire [4:0] out_off = addr_i - `OUT_MAP_BASE;
    wire [2:0] out_idx = out_off[2:0];
    wire       osc_wr  = wr_i && (addr_i == `OSC_CTRL_ADDR);
    wire [7:0] osc_lo  = wdata_i[7:0];
    wire [6:0] per_out = {compare2_out_i, compare1_out_i, spi_select_out_i, spi_clock_out_i,
                          spi_data_out_i, serial_rts_out_i, serial_tx_out_i};

    // ----------------------------------------
    // combinational: read mux, routing, checks
    // ----------------------------------------
    always @* begin
        nxt_rdata = 16'h0000;
        if (in_hit)
            nxt_rdata = in_map_ff[in_idx];
        else if (out_hit)
            nxt_rdata = out_map_ff[out_idx];
        else if (addr_i == `OSC_CTRL_ADDR)
            nxt_rdata = {9'h000, lock_ff, 6'h00};
        else if (addr_i == `IRQ_STAT_ADDR)
            nxt_rdata = {13'h0000, stat_ff};
        else if (addr_i == `IRQ_MASK_ADDR)
            nxt_rdata = {13'h0000, mask_ff};

        // shadows follow every legal write, so any difference is a disturbance
        mismatch = 1'b0;
        for (i = 0; i < NUM_IN; i = i + 1)
            if (in_map_ff[i] != in_shad_ff[i])
                mismatch = 1'b1;
        for (i = 0; i < NUM_OUT; i = i + 1)
            if (out_map_ff[i] != out_shad_ff[i])
                mismatch = 1'b1;

        // per pin output selection
        for (i = 0; i < NOPIN; i = i + 1) begin
            code = i[0] ? out_map_ff[i/2][12:8] : out_map_ff[i/2][4:0];
            drv  = route_out(code, per_out);
            if (drv[1]) begin
                nxt_pin_out[i] = drv[0];
                nxt_pin_oe[i]  = 1'b1;
            end else begin
                nxt_pin_out[i] = port_data_i[i];
                nxt_pin_oe[i]  = port_drive_i[i];
            end
        end

        // pin levels are the synchronised copy; direction is the port's business
        nxt_pin_sel[0]  = route_in(in_map_ff[0][12:8], sync2_ff);
        nxt_pin_sel[1]  = route_in(in_map_ff[1][4:0], sync2_ff);
        nxt_pin_sel[2]  = route_in(in_map_ff[2][4:0], sync2_ff);
        nxt_pin_sel[3]  = route_in(in_map_ff[2][12:8], sync2_ff);
        nxt_pin_sel[4]  = route_in(in_map_ff[3][4:0], sync2_ff);
        nxt_pin_sel[5]  = route_in(in_map_ff[3][12:8], sync2_ff);
        nxt_pin_sel[6]  = route_in(in_map_ff[4][4:0], sync2_ff);
        nxt_pin_sel[7]  = route_in(in_map_ff[4][12:8], sync2_ff);
        nxt_pin_sel[8]  = route_in(in_map_ff[5][4:0], sync2_ff);
        nxt_pin_sel[9]  = route_in(in_map_ff[6][4:0], sync2_ff);
        nxt_pin_sel[10] = route_in(in_map_ff[6][12:8], sync2_ff);
        nxt_pin_sel[11] = route_in(in_map_ff[7][4:0], sync2_ff);
        nxt_pin_sel[12] = route_in(in_map_ff[7][12:8], sync2_ff);
        nxt_pin_sel[13] = route_in(in_map_ff[8][4:0], sync2_ff);

        events = {`EV_COUNT{1'b0}};
        events[`EV_REFUSED]  = wr_i && (in_hit || out_hit) && lock_ff;
        events[`EV_MISMATCH] = mismatch;
        events[`EV_LOCK_CHG] = osc_wr && (key_ff == KEY_OPEN) && (wdata_i[`LOCK_BIT] != lock_ff)
                               && !(!wdata_i[`LOCK_BIT] && fuse_ff && set_once_ff);
    end

    // ----------------------------------------
    // sequential
    // ----------------------------------------
    // reset works even while the clock enable is low
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            for (j = 0; j < NUM_IN; j = j + 1) begin
                in_map_ff[j]  <= `IN_MAP_RST & in_mask(j[3:0]);
                in_shad_ff[j] <= `IN_MAP_RST & in_mask(j[3:0]);
            end
            for (j = 0; j < NUM_OUT; j = j + 1) begin
                out_map_ff[j]  <= `OUT_MAP_RST;
                out_shad_ff[j] <= `OUT_MAP_RST;
            end
            sync1_ff    <= {NUM_PINS{1'b0}};
            sync2_ff    <= {NUM_PINS{1'b0}};
            key_ff      <= KEY_IDLE;
            lock_ff     <= `LOCK_RST;
            set_once_ff <= 1'b0;
            fuse_ff     <= 1'b1;
            stat_ff     <= {`EV_COUNT{1'b0}};
            mask_ff     <= {`EV_COUNT{1'b0}};
            irq_ff      <= 1'b0;
            cfg_rst_ff  <= 1'b0;
            rdata_ff    <= 16'h0000;
            pin_out_ff  <= {NOPIN{1'b0}};
            pin_oe_ff   <= {NOPIN{1'b0}};
            pin_sel_ff  <= 14'h0000;
        end else if (ce_i) begin
            sync1_ff <= pin_in_i;
            sync2_ff <= sync1_ff;
            // fuse read as set when unprogrammed; sampled each cycle after reset
            fuse_ff  <= osc_config_word_i[`FUSE_BIT];

            // map writes; refused while locked, which sets the refused status bit
            if (wr_i && in_hit && !lock_ff) begin
                in_map_ff[in_idx]  <= wdata_i & in_mask(in_idx);
                in_shad_ff[in_idx] <= wdata_i & in_mask(in_idx);
            end
            if (wr_i && out_hit && !lock_ff) begin
                out_map_ff[out_idx]  <= wdata_i & `MASK_BOTH;
                out_shad_ff[out_idx] <= wdata_i & `MASK_BOTH;
            end

            // unlock sequence; only writes to the control register advance it
            if (osc_wr) begin
                case (key_ff)
                    KEY_IDLE: begin
                        key_ff <= (osc_lo == `KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                    end
                    KEY_HALF: begin
                        if (osc_lo == `KEY_SECOND)
                            key_ff <= KEY_OPEN;
                        else if (osc_lo == `KEY_FIRST)
                            key_ff <= KEY_HALF;
                        else
                            key_ff <= KEY_IDLE;
                    end
                    KEY_OPEN: begin
                        key_ff <= KEY_IDLE;
                        if (wdata_i[`LOCK_BIT]) begin
                            lock_ff     <= 1'b1;
                            set_once_ff <= 1'b1;
                        end else if (!(fuse_ff && set_once_ff)) begin
                            lock_ff <= 1'b0;
                        end
                    end
                    default: begin
                        key_ff <= KEY_IDLE;
                    end
                endcase
            end
            // lock holds across any number of map writes

            // sticky status: a new event beats a simultaneous clear
            if (wr_i && addr_i == `IRQ_STAT_ADDR)
                stat_ff <= (stat_ff & ~wdata_i[`EV_COUNT-1:0]) | events;
            else
                stat_ff <= stat_ff | events;
            if (wr_i && addr_i == `IRQ_MASK_ADDR)
                mask_ff <= wdata_i[`EV_COUNT-1:0];
            irq_ff <= |(stat_ff & mask_ff);

            cfg_rst_ff <= mismatch;
            rdata_ff   <= rd_i ? nxt_rdata : 16'h0000;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
            pin_sel_ff <= nxt_pin_sel;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o              = rdata_ff;
    assign pin_out_o            = pin_out_ff;
    assign pin_oe_o             = pin_oe_ff;
    assign ext_irq1_o           = pin_sel_ff[0];
    assign ext_irq2_o           = pin_sel_ff[1];
    assign timer2_clk_o         = pin_sel_ff[2];
    assign timer3_clk_o         = pin_sel_ff[3];
    assign capture1_o           = pin_sel_ff[4];
    assign capture2_o           = pin_sel_ff[5];
    assign capture7_o           = pin_sel_ff[6];
    assign capture8_o           = pin_sel_ff[7];
    assign compare_fault_a_in_o = pin_sel_ff[8];
    assign serial_rx_o          = pin_sel_ff[9];
    assign serial_cts_o         = pin_sel_ff[10];
    assign spi_data_in_o        = pin_sel_ff[11];
    assign spi_clock_in_o       = pin_sel_ff[12];
    assign spi_select_in_o      = pin_sel_ff[13];
    assign pin_map_lock_o       = lock_ff;
    assign config_reset_o       = cfg_rst_ff;
    assign irq_o                = irq_ff;

endmodule // peripheral_pin_remap

`default_nettype wire

//--- testbench/pin_remap_props.sv
// port-level assertion checker of the pin remap matrix
`include "pin_remap_map.vh"
`default_nettype none
module pin_remap_props #(
    parameter NUM_PINS = 26,
    parameter NUM_OUT  = 8
) (
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire logic                 ce_i,
    input wire logic [4:0]           addr_i,
    input wire logic [15:0]          wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [15:0]          rdata_o,
    input wire logic [7:0]           osc_config_word_i,
    input wire logic [NUM_PINS-1:0]  pin_in_i,
    input wire logic [2*NUM_OUT-1:0] port_data_i,
    input wire logic [2*NUM_OUT-1:0] port_drive_i,
    input wire logic [2*NUM_OUT-1:0] pin_out_o,
    input wire logic [2*NUM_OUT-1:0] pin_oe_o,
    input wire logic                 serial_tx_out_i,
    input wire logic                 serial_rts_out_i,
    input wire logic                 spi_data_out_i,
    input wire logic                 spi_clock_out_i,
    input wire logic                 spi_select_out_i,
    input wire logic                 compare1_out_i,
    input wire logic                 compare2_out_i,
    input wire logic                 ext_irq1_o,
    input wire logic                 pin_map_lock_o,
    input wire logic                 config_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // shadow of pin 0 and irq1 selectors
    // ----------------------------------------
    logic [4:0] out_sel_ff;
    logic [4:0] in_sel_ff;
    logic       take_w;
    logic [1:0] exp_w;
    logic       pin_w;
    assign take_w = wr_i && ce_i && !pin_map_lock_o;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            out_sel_ff <= `OUT_NULL;
            in_sel_ff  <= `SEL_GROUND;
        end else if (take_w && addr_i == `OUT_MAP_BASE) begin
            out_sel_ff <= wdata_i[4:0];
        end else if (take_w && addr_i == `IN_MAP_BASE) begin
            in_sel_ff <= wdata_i[12:8];
        end
    end
    // unlisted codes fall back to the port, so one table serves null and routed cases
    always_comb begin
        case (out_sel_ff)
            `OUT_TX:  exp_w = {1'b1, serial_tx_out_i};
            `OUT_RTS: exp_w = {1'b1, serial_rts_out_i};
            `OUT_SDO: exp_w = {1'b1, spi_data_out_i};
            `OUT_SCK: exp_w = {1'b1, spi_clock_out_i};
            `OUT_SS:  exp_w = {1'b1, spi_select_out_i};
            `OUT_OC1: exp_w = {1'b1, compare1_out_i};
            `OUT_OC2: exp_w = {1'b1, compare2_out_i};
            default:  exp_w = {port_drive_i[0], port_data_i[0]};
        endcase
    end
    assign pin_w = (in_sel_ff <= `SEL_LAST_PIN) ? pin_in_i[in_sel_ff] : 1'b0;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_UNUSED_ZERO: assert property (rd_i && addr_i <= `OUT_MAP_LAST |=>
        (rdata_o & ~`MASK_BOTH) == 16'h0000) else $error("unused map bits read nonzero");
    AST_LOCK_HOLD: assert property (!(wr_i && addr_i == `OSC_CTRL_ADDR) |=>
        $stable(pin_map_lock_o)) else $error("lock moved without a control write");
    AST_LOCK_CAUSE: assert property ($changed(pin_map_lock_o) |->
        $past(wr_i) && $past(addr_i) == `OSC_CTRL_ADDR && pin_map_lock_o == $past(wdata_i[`LOCK_BIT]))
        else $error("lock changed without its write");
    AST_FUSE_ONEWAY: assert property (osc_config_word_i[`FUSE_BIT] && pin_map_lock_o |=>
        pin_map_lock_o) else $error("lock cleared under one-way fuse");
    AST_NO_MISMATCH: assert property (config_reset_o == 1'b0)
        else $error("shadow mismatch without disturbance");
    AST_PIN0_NULL: assert property (rstn_i && out_sel_ff == `OUT_NULL |=>
        pin_oe_o[0] == $past(port_drive_i[0]) && pin_out_o[0] == $past(port_data_i[0]))
        else $error("null pin not under port control");
    AST_PIN0_ROUTE: assert property (rstn_i |=>
        {pin_oe_o[0], pin_out_o[0]} == $past(exp_w)) else $error("pin 0 output route wrong");
    AST_IN_ROUTE: assert property ($stable(in_sel_ff) [*3] |->
        ext_irq1_o == $past(pin_w, 3)) else $error("irq1 input route wrong");
endmodule // pin_remap_props

bind peripheral_pin_remap pin_remap_props #(.NUM_PINS(NUM_PINS), .NUM_OUT(NUM_OUT)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .osc_config_word_i(osc_config_word_i), .pin_in_i(pin_in_i),
    .port_data_i(port_data_i), .port_drive_i(port_drive_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .serial_tx_out_i(serial_tx_out_i), .serial_rts_out_i(serial_rts_out_i), .spi_data_out_i(spi_data_out_i),
    .spi_clock_out_i(spi_clock_out_i), .spi_select_out_i(spi_select_out_i), .compare1_out_i(compare1_out_i),
    .compare2_out_i(compare2_out_i), .ext_irq1_o(ext_irq1_o), .pin_map_lock_o(pin_map_lock_o),
    .config_reset_o(config_reset_o));
`default_nettype wire

//--- testbench/periph_model.sv
// behavioural peripherals and port pins around the pin remap matrix
`default_nettype none
module periph_model (
    input  wire logic   clk_i,
    output logic [25:0] pin_in_o,
    output logic [15:0] port_data_o,
    output logic [15:0] port_drive_o,
    output logic [6:0]  periph_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt_ff = 32'h0000_0000;
    // pin levels flip every cycle except when their counter bit toggles, so a stale route cannot match by chance
    always @(posedge clk_i) begin
        cnt_ff <= cnt_ff + 32'h0000_0001;
    end
    assign pin_in_o     = cnt_ff[28:3] ^ {26{cnt_ff[0]}};
    assign port_data_o  = cnt_ff[15:0] ^ 16'h5a3c;
    assign port_drive_o = {8'h00, cnt_ff[9:2]}; // upper pins stay inputs
    assign periph_o     = cnt_ff[6:0] ^ cnt_ff[13:7];
endmodule // periph_model
`default_nettype wire

//--- testbench/peripheral_pin_remap_tb_top.sv
// self-checking bench of the pin remap matrix
`include "pin_remap_map.vh"
`default_nettype none
module peripheral_pin_remap_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i;
    logic        rstn_i;
    logic [4:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  osc_word;
    logic [15:0] rdata_o;
    logic [15:0] pin_out_o;
    logic [15:0] pin_oe_o;
    logic [15:0] pdat_w;
    logic [15:0] pdrv_w;
    logic [25:0] pins_w;
    logic [6:0]  per_w;
    logic        irq1_w;
    logic        tmr2_w;
    logic        tmr3_w;
    logic        lock_w;
    logic        cfg_rst_w;
    logic        irq_w;
    logic [4:0]  codes [9];
    logic [3:0]  e;
    int          errors;
    int          checks;
    int          cyc;
    periph_model model (.clk_i(clk_i), .pin_in_o(pins_w), .port_data_o(pdat_w), .port_drive_o(pdrv_w),
        .periph_o(per_w));
    peripheral_pin_remap dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .osc_config_word_i(osc_word), .pin_in_i(pins_w), .port_data_i(pdat_w),
        .port_drive_i(pdrv_w), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .serial_tx_out_i(per_w[0]),
        .serial_rts_out_i(per_w[1]), .spi_data_out_i(per_w[2]), .spi_clock_out_i(per_w[3]),
        .spi_select_out_i(per_w[4]), .compare1_out_i(per_w[5]), .compare2_out_i(per_w[6]),
        .ext_irq1_o(irq1_w), .ext_irq2_o(), .timer2_clk_o(tmr2_w), .timer3_clk_o(tmr3_w), .capture1_o(),
        .capture2_o(), .capture7_o(), .capture8_o(), .compare_fault_a_in_o(), .serial_rx_o(), .serial_cts_o(),
        .spi_data_in_o(), .spi_clock_in_o(), .spi_select_in_o(), .pin_map_lock_o(lock_w),
        .config_reset_o(cfg_rst_w), .irq_o(irq_w));
    always #50 clk_i = ~clk_i;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] in_mask(input int i);
        case (i)
            0:       return `MASK_HI;
            1, 5, 8: return `MASK_LO;
            default: return `MASK_BOTH;
        endcase
    endfunction
    function automatic logic [1:0] exp_pin(input logic [4:0] c, input int k);
        case (c)
            `OUT_TX:  return {1'b1, per_w[0]};
            `OUT_RTS: return {1'b1, per_w[1]};
            `OUT_SDO: return {1'b1, per_w[2]};
            `OUT_SCK: return {1'b1, per_w[3]};
            `OUT_SS:  return {1'b1, per_w[4]};
            `OUT_OC1: return {1'b1, per_w[5]};
            `OUT_OC2: return {1'b1, per_w[6]};
            default:  return {pdrv_w[k], pdat_w[k]};
        endcase
    endfunction
    task automatic end_sim();
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] x);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, x);
    endtask
    task automatic key(input logic [7:0] v);
        wr(`OSC_CTRL_ADDR, {8'h00, `KEY_FIRST});
        wr(`OSC_CTRL_ADDR, {8'h00, `KEY_SECOND});
        wr(`OSC_CTRL_ADDR, {8'h00, v});
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk_i    = 1'b0;
        rstn_i   = 1'b0;
        addr_i   = 5'h00;
        wdata_i  = 16'h0000;
        wr_i     = 1'b0;
        rd_i     = 1'b0;
        osc_word = 8'h20;
        codes = '{`OUT_NULL, `OUT_TX, `OUT_RTS, `OUT_SDO, `OUT_SCK, `OUT_SS, `OUT_OC1, `OUT_OC2, 5'h05};
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            rdc(i[4:0], (i < 9) ? in_mask(i) : `OUT_MAP_RST);
            wr(i[4:0], 16'hffff);
            rdc(i[4:0], (i < 9) ? in_mask(i) : `MASK_BOTH);
        end
        wr(5'h1a, 16'hffff);
        rdc(5'h1a, 16'h0000);
        foreach (codes[i]) begin
            wr(`OUT_MAP_BASE, {3'h0, codes[i], 3'h0, codes[i]});
            @(posedge clk_i);
            #1 e = {exp_pin(codes[i], 1), exp_pin(codes[i], 0)};
            @(posedge clk_i);
            #1 chk({12'h000, pin_oe_o[1], pin_out_o[1], pin_oe_o[0], pin_out_o[0]}, {12'h000, e});
        end
        wr(`IN_MAP_BASE, 16'h1900);
        wr(`IN_MAP_BASE + 5'h02, 16'h1f10);
        repeat (4) @(posedge clk_i);
        #1 e = {2'b00, pins_w[25], pins_w[16]};
        repeat (3) @(posedge clk_i);
        #1 chk({13'h0000, tmr3_w, irq1_w, tmr2_w}, {12'h000, e});
        key(8'h40);
        #1 chk({15'h0000, lock_w}, 16'h0001);
        rdc(`OSC_CTRL_ADDR, 16'h0040);
        wr(`OUT_MAP_BASE, 16'h0303);
        rdc(`OUT_MAP_BASE, 16'h0505);
        rdc(`IRQ_STAT_ADDR, 16'h0005);
        wr(`IRQ_MASK_ADDR, 16'h0001);
        @(posedge clk_i);
        #1 chk({15'h0000, irq_w}, 16'h0001);
        wr(`IRQ_STAT_ADDR, 16'h0007);
        @(posedge clk_i);
        #1 chk({15'h0000, irq_w}, 16'h0000);
        key(8'h00);
        #1 chk({15'h0000, lock_w}, 16'h0001);
        osc_word <= 8'h00;
        wr(`OSC_CTRL_ADDR, 16'h0046);
        wr(`OSC_CTRL_ADDR, 16'h0012);
        wr(`OSC_CTRL_ADDR, 16'h0057);
        wr(`OSC_CTRL_ADDR, 16'h0000);
        #1 chk({15'h0000, lock_w}, 16'h0001);
        wr(`OSC_CTRL_ADDR, 16'h0046);
        wr(`IRQ_MASK_ADDR, 16'h0000);
        wr(`OSC_CTRL_ADDR, 16'h0057);
        wr(`OSC_CTRL_ADDR, 16'h0000);
        #1 chk({15'h0000, lock_w}, 16'h0000);
        wr(`OUT_MAP_BASE, 16'h0303);
        wr(`OUT_MAP_BASE + 5'h01, 16'h0707);
        rdc(`OUT_MAP_BASE, 16'h0303);
        rdc(`OUT_MAP_BASE + 5'h01, 16'h0707);
        key(8'h40);
        key(8'h00);
        #1 chk({15'h0000, lock_w}, 16'h0000);
        chk({15'h0000, cfg_rst_w}, 16'h0000);
        rstn_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdc(`IN_MAP_BASE, `MASK_HI);
        rdc(`OUT_MAP_BASE, `OUT_MAP_RST);
        chk({15'h0000, lock_w}, 16'h0000);
        end_sim();
    end
endmodule // peripheral_pin_remap_tb_top
`default_nettype wire
